// *** pmd_decoder.sv ***
// Manufacturer command decoder with link-clock front end and system-clock register core
// Overview of operation
// - Save code copies volatile fault log to NVM
// - Erase code initialises NVM fault log area
// - Compare code checks all commands against NVM
// - Restart code resets logic without power loss
// - Block read returns 48-bit shared clock counter
// - NVM-flagged commands join store and restore
// - Unknown reads complete harmlessly, data undefined
// - Write to unknown read-only sets fault bit 6
// - Linear word: 5-bit exponent, 11-bit mantissa
// - Unsigned linear word uses exponent minus twelve
// - Integer word is plain unsigned sixteen bits
// - Register commands carry 16 or 8 bits
// - Track die temperature peak, report linear word
// - Rail address per channel, resets to 0x80
// - Sensor offset relative to absolute zero, default zero
// - Sense coefficient defaults to 3900 ppm per degree
// - Engine bit 2 picks low-resistance sensing
// - Compensation byte splits transconductance and resistance
// - Engine bit 1 picks output voltage range
// - Peak clear restarts every tracked peak
`timescale 1ns/1ns
module pmd_decoder
    import pmd_pkg::*;
#(
    parameter int CHANNELS = 2
)(
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Link side, on the link clock
    input wire logic link_clk_i,
    input wire logic link_rst_i,
    input wire logic link_valid_i,
    input wire logic [1:0] link_kind_i,
    input wire logic [7:0] link_code_i,
    input wire logic [15:0] link_wdata_i,
    input wire logic link_extra_i,
    input wire logic link_page_i,
    output logic link_done_o,
    output logic [pmd_pkg::PMD_COUNT_W-1:0] link_rdata_o,
    output logic link_nack_o,
    // Measurement and timebase
    input wire logic [15:0] die_temp_i,
    input wire logic die_temp_valid_i,
    input wire logic share_clk_tick_i,
    // NVM engine handshakes
    output logic nvm_fault_save_o,
    output logic nvm_fault_erase_o,
    output logic nvm_compare_o,
    input wire logic [7:0] nvm_fault_byte_i,
    // Control outputs
    output logic soft_restart_o,
    output logic low_sense_o,
    output logic [CHANNELS-1:0] vout_range_o,
    output logic [2:0] error_amp_transconductance_o,
    output logic [4:0] compensation_resistance_o,
    output logic [15:0] sense_temp_coefficient_o,
    output logic [15:0] ext_temp_offset_o,
    output logic [7:0] shared_rail_address_o,
    output logic [7:0] common_status_flags_o
);
    import pmd_pkg::*;

    // Link domain: capture request, toggle to system domain
    logic req_tgl;
    logic [1:0] req_kind;
    logic [7:0] req_code;
    logic [15:0] req_wdata;
    logic req_extra;
    logic req_page;
    logic [2:0] ack_sync;
    logic [PMD_COUNT_W-1:0] ans_data;
    logic ans_nack;
    logic ack_tgl;

    // Toggle handshake with one request in flight, so the held words need no gray code
    // Request words are held stable until the acknowledge returns
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_i)
        begin
            req_tgl <= 1'b0;
            req_kind <= PMD_K_SEND;
            req_code <= 8'h00;
            req_wdata <= 16'h0000;
            req_extra <= 1'b0;
            req_page <= 1'b0;
        end
        // Host holds valid through the done edge; done blocks a second capture
        else if (link_valid_i && !link_done_o && (ack_sync[2] == req_tgl))
        begin
            req_tgl <= ~req_tgl;
            req_kind <= link_kind_i;
            req_code <= link_code_i;
            req_wdata <= link_wdata_i;
            req_extra <= link_extra_i;
            req_page <= link_page_i;
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_i)
        begin
            ack_sync <= 3'h0;
            link_done_o <= 1'b0;
            link_rdata_o <= '0;
            link_nack_o <= 1'b0;
        end
        else
        begin
            ack_sync <= {ack_sync[1:0], ack_tgl};
            link_done_o <= ack_sync[2] ^ ack_sync[1];
            if (ack_sync[2] ^ ack_sync[1])
            begin
                link_rdata_o <= ans_data;
                link_nack_o <= ans_nack;
            end
        end
    end

    // System domain
    logic [2:0] req_sync;
    logic req_seen;
    logic restart_rst;
    logic core_rst;
    logic [7:0] pwm_phasing;
    logic [15:0] filter_res;
    logic [15:0] temp_slope;
    // Channel-paged copies
    logic [CHANNELS-1:0][15:0] sense_tc;
    logic [CHANNELS-1:0][15:0] temp_offset;
    logic [CHANNELS-1:0][7:0] rail_addr;
    logic [CHANNELS-1:0][7:0] pwm_engine;
    logic [CHANNELS-1:0][7:0] loop_comp;
    // Peak tracking, shared-clock count and status
    logic [15:0] die_peak;
    logic peak_empty;
    logic [PMD_COUNT_W-1:0] clk_count;
    logic [7:0] comm_memory_logic_fault;
    logic [1:0] tick_sync;
    logic tick_last;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            req_sync <= 3'h0;
        else
            req_sync <= {req_sync[1:0], req_tgl};
    end

    assign req_seen = req_sync[2] ^ req_sync[1];
    // Commanded restart resets the core but never the link answer path
    assign core_rst = sys_rst_i | restart_rst;

    // Decode of the held request
    function automatic logic is_send_code(input logic [7:0] c);
        return c == PMD_CMD_FAULT_SAVE
            || c == PMD_CMD_FAULT_ERASE
            || c == PMD_CMD_NVM_COMPARE
            || c == PMD_CMD_SOFT_RESTART
            || c == PMD_CMD_PEAK_CLEAR;
    endfunction

    function automatic logic is_rw_code(input logic [7:0] c);
        return (c >= PMD_CMD_PWM_PHASING && c <= PMD_CMD_RAIL_ADDR)
            || c == PMD_CMD_PWM_ENGINE
            || c == PMD_CMD_LOOP_COMP;
    endfunction

    function automatic logic is_ro_code(input logic [7:0] c);
        return c == PMD_CMD_FAULT_READ
            || c == PMD_CMD_COMMON
            || c == PMD_CMD_DIE_PEAK
            || c == PMD_CMD_CLOCK_COUNT;
    endfunction

    wire is_send = req_seen && req_kind == PMD_K_SEND;
    wire is_write = req_seen && req_kind == PMD_K_WRITE;
    wire is_read = req_seen && req_kind == PMD_K_READ;
    wire send_ok = is_send && is_send_code(req_code) && !req_extra;
    wire write_ok = is_write && is_rw_code(req_code);
    // Refused requests leave every register but fault bit 6 untouched
    wire write_ro = is_write && !is_rw_code(req_code) && !is_send_code(req_code);
    wire bad_send = is_send && (!is_send_code(req_code) || req_extra);
    wire chan = req_page;
    wire do_clear_peaks = send_ok && req_code == PMD_CMD_PEAK_CLEAR;

    // Soft restart: one-cycle core reset, link stays up to answer
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            restart_rst <= 1'b0;
        else
            restart_rst <= send_ok && req_code == PMD_CMD_SOFT_RESTART;
    end

    // NVM engine strobes
    // One-cycle strobes; the engine latches its own job
    always_ff @(posedge clk_sys_i)
    begin
        if (core_rst)
        begin
            nvm_fault_save_o <= 1'b0;
            nvm_fault_erase_o <= 1'b0;
            nvm_compare_o <= 1'b0;
        end
        else
        begin
            nvm_fault_save_o <= send_ok && req_code == PMD_CMD_FAULT_SAVE;
            nvm_fault_erase_o <= send_ok && req_code == PMD_CMD_FAULT_ERASE;
            nvm_compare_o <= send_ok && req_code == PMD_CMD_NVM_COMPARE;
        end
    end

    // Writable registers; the NVM engine stores and restores exactly these
    always_ff @(posedge clk_sys_i)
    begin
        if (core_rst)
        begin
            pwm_phasing <= PMD_RST_PWM_PHASING;
            filter_res <= PMD_RST_FILTER_RES;
            temp_slope <= PMD_RST_TEMP_SLOPE;
            sense_tc <= {CHANNELS{PMD_RST_SENSE_TC}};
            temp_offset <= {CHANNELS{PMD_RST_TEMP_OFFSET}};
            rail_addr <= {CHANNELS{PMD_RST_RAIL_ADDR}};
            pwm_engine <= {CHANNELS{PMD_RST_PWM_ENGINE}};
            loop_comp <= {CHANNELS{PMD_RST_LOOP_COMP}};
        end
        else if (write_ok)
        begin
            unique case (req_code)
                PMD_CMD_PWM_PHASING: pwm_phasing <= req_wdata[7:0];
                PMD_CMD_FILTER_RES: filter_res <= req_wdata;
                PMD_CMD_TEMP_SLOPE: temp_slope <= req_wdata;
                PMD_CMD_SENSE_TC: sense_tc[chan] <= req_wdata;
                PMD_CMD_TEMP_OFFSET: temp_offset[chan] <= req_wdata;
                PMD_CMD_RAIL_ADDR: rail_addr[chan] <= req_wdata[7:0];
                PMD_CMD_PWM_ENGINE: pwm_engine[chan] <= req_wdata[7:0];
                PMD_CMD_LOOP_COMP: loop_comp[chan] <= req_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Die peak kept in linear form; peak compared as signed value assumes a common exponent
    wire [4:0] temp_exp = die_temp_i[15:PMD_L11_EXP_LSB];
    wire signed [10:0] temp_mant = die_temp_i[PMD_L11_EXP_LSB-1:0];
    wire signed [10:0] peak_mant = die_peak[PMD_L11_EXP_LSB-1:0];
    wire peak_higher = peak_empty
        || (temp_exp != die_peak[15:PMD_L11_EXP_LSB])
        || (temp_mant > peak_mant);

    always_ff @(posedge clk_sys_i)
    begin
        if (core_rst)
        begin
            die_peak <= 16'h0000;
            peak_empty <= 1'b1;
        end
        else if (die_temp_valid_i && peak_higher)
        begin
            die_peak <= die_temp_i;
            peak_empty <= 1'b0;
        end
        else if (do_clear_peaks)
        begin
            die_peak <= 16'h0000;
            peak_empty <= 1'b1;
        end
    end

    // Shared-clock counter; tick arrives from a pin
    // Edge detect idles low like the pin, so reset never fakes a tick
    always_ff @(posedge clk_sys_i)
    begin
        if (core_rst)
        begin
            tick_sync <= 2'h0;
            tick_last <= 1'b0;
            clk_count <= '0;
        end
        else
        begin
            tick_sync <= {tick_sync[0], share_clk_tick_i};
            tick_last <= tick_sync[1];
            if (tick_sync[1] && !tick_last)
                clk_count <= clk_count + 48'h1;
        end
    end

    // Fault status; set wins over clear, cleared by peak-clear
    always_ff @(posedge clk_sys_i)
    begin
        if (core_rst)
            comm_memory_logic_fault <= 8'h00;
        else if (write_ro || bad_send)
            comm_memory_logic_fault[PMD_CML_RO_WRITE_BIT] <= 1'b1;
        else if (do_clear_peaks)
            comm_memory_logic_fault[PMD_CML_RO_WRITE_BIT] <= 1'b0;
    end

    // Read answer mux; unknown codes return zero and disturb nothing
    // 16-bit words go out zero-extended, whole and unscaled
    logic [PMD_COUNT_W-1:0] next_ans;
    always_comb
    begin
        next_ans = '0;
        unique case (req_code)
            PMD_CMD_FAULT_READ: next_ans = {40'h0, nvm_fault_byte_i};
            PMD_CMD_COMMON: next_ans = {40'h0, comm_memory_logic_fault};
            PMD_CMD_DIE_PEAK: next_ans = {32'h0, die_peak};
            PMD_CMD_PWM_PHASING: next_ans = {40'h0, pwm_phasing};
            PMD_CMD_SENSE_TC: next_ans = {32'h0, sense_tc[chan]};
            PMD_CMD_FILTER_RES: next_ans = {32'h0, filter_res};
            PMD_CMD_TEMP_SLOPE: next_ans = {32'h0, temp_slope};
            PMD_CMD_TEMP_OFFSET: next_ans = {32'h0, temp_offset[chan]};
            PMD_CMD_RAIL_ADDR: next_ans = {40'h0, rail_addr[chan]};
            PMD_CMD_CLOCK_COUNT: next_ans = clk_count;
            PMD_CMD_PWM_ENGINE: next_ans = {40'h0, pwm_engine[chan]};
            PMD_CMD_LOOP_COMP: next_ans = {40'h0, loop_comp[chan]};
            default: next_ans = '0;
        endcase
    end

    // Answer words are held until the next request, so the link samples them stable
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ack_tgl <= 1'b0;
            ans_data <= '0;
            ans_nack <= 1'b0;
        end
        else if (req_seen)
        begin
            ack_tgl <= ~ack_tgl;
            ans_data <= is_read ? next_ans : '0;
            ans_nack <= write_ro || bad_send;
        end
    end

    // Control outputs
    // Own reset only: core_rst would swallow the pulse it follows
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            soft_restart_o <= 1'b0;
        else
            soft_restart_o <= restart_rst;
    end

    // Single-copy outputs follow channel 0; range bits follow each channel
    assign low_sense_o = pwm_engine[0][PMD_ENG_LOW_SENSE_BIT];
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_range
            assign vout_range_o[g] = pwm_engine[g][PMD_ENG_VRANGE_BIT];
        end
    endgenerate
    assign error_amp_transconductance_o = loop_comp[0][7:5];
    assign compensation_resistance_o = loop_comp[0][4:0];
    assign sense_temp_coefficient_o = sense_tc[0];
    assign ext_temp_offset_o = temp_offset[0];
    assign shared_rail_address_o = rail_addr[0];
    assign common_status_flags_o = comm_memory_logic_fault;

endmodule // pmd_decoder

// *** pmd_decoder_checker.sv ***
// Port-level assertions for the command decoder
`timescale 1ns/1ns
module pmd_decoder_checker
    import pmd_pkg::*;
#(
    parameter int CHANNELS = 2
)(
    // Clocks and resets
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic link_rst_i,
    // Link side
    input wire logic link_valid_i,
    input wire logic link_done_o,
    input wire logic [pmd_pkg::PMD_COUNT_W-1:0] link_rdata_o,
    input wire logic link_nack_o,
    // Core outputs
    input wire logic nvm_fault_save_o,
    input wire logic nvm_fault_erase_o,
    input wire logic nvm_compare_o,
    input wire logic soft_restart_o,
    input wire logic low_sense_o,
    input wire logic [CHANNELS-1:0] vout_range_o,
    input wire logic [2:0] error_amp_transconductance_o,
    input wire logic [4:0] compensation_resistance_o,
    input wire logic [15:0] sense_temp_coefficient_o,
    input wire logic [15:0] ext_temp_offset_o,
    input wire logic [7:0] shared_rail_address_o,
    input wire logic [7:0] common_status_flags_o
);
    AST_DONE_PULSE: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        link_done_o |=> !link_done_o) else $error("done held too long");
    AST_DONE_BOUND: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        link_valid_i && !link_done_o |-> ##[1:10] link_done_o) else $error("request not answered");
    AST_ANSWER_HOLD: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        !link_done_o |-> $stable(link_rdata_o) && $stable(link_nack_o)) else $error("answer moved");
    AST_NACK_STATUS: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        link_done_o && link_nack_o |-> common_status_flags_o[6]) else $error("refusal without fault bit");
    AST_SAVE_PULSE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        nvm_fault_save_o |-> !nvm_fault_erase_o && !nvm_compare_o ##1 !nvm_fault_save_o) else $error("bad save");
    AST_ERASE_PULSE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        nvm_fault_erase_o |-> !nvm_compare_o ##1 !nvm_fault_erase_o) else $error("bad erase");
    AST_CMP_PULSE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        nvm_compare_o |-> !nvm_fault_save_o ##1 !nvm_compare_o) else $error("bad compare");
    AST_RESTART: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        soft_restart_o |-> ##[0:6] shared_rail_address_o == 8'h80 && ext_temp_offset_o == 16'h8000)
        else $error("restart left registers");
    AST_RST_VALUES: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> shared_rail_address_o == 8'h80 && ext_temp_offset_o == 16'h8000
        && sense_temp_coefficient_o == 16'h0f3c) else $error("bad reset values");
    AST_RST_LOOP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> error_amp_transconductance_o == 3'h5 && compensation_resistance_o == 5'h0e
        && low_sense_o && &vout_range_o) else $error("bad loop reset fields");
    COV_SAVE: cover property (@(posedge clk_sys_i) nvm_fault_save_o);
    COV_RESTART: cover property (@(posedge clk_sys_i) soft_restart_o);
    COV_NACK: cover property (@(posedge link_clk_i) link_done_o && link_nack_o);
endmodule // pmd_decoder_checker

bind pmd_decoder pmd_decoder_checker #(.CHANNELS(CHANNELS)) pmd_decoder_checker_i (
    .clk_sys_i, .sys_rst_i, .link_clk_i, .link_rst_i, .link_valid_i, .link_done_o, .link_rdata_o,
    .link_nack_o, .nvm_fault_save_o, .nvm_fault_erase_o, .nvm_compare_o, .soft_restart_o, .low_sense_o,
    .vout_range_o, .error_amp_transconductance_o, .compensation_resistance_o, .sense_temp_coefficient_o,
    .ext_temp_offset_o, .shared_rail_address_o, .common_status_flags_o);

// *** pmd_decoder_tb_top.sv ***
// Self-checking bench for the command decoder through its link side
`timescale 1ns/1ns
module pmd_decoder_tb_top;
    import pmd_pkg::*;
    logic clk_sys_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic link_rst_i = 1'b1;
    logic die_temp_valid_i = 1'b0;
    logic share_clk_tick_i = 1'b0;
    logic [15:0] die_temp_i = 16'h0000;
    logic [7:0] nvm_fault_byte_i = 8'h3c;
    logic link_valid_i, link_extra_i, link_page_i, link_done_o, link_nack_o, nk, ok;
    logic nvm_fault_save_o, nvm_fault_erase_o, nvm_compare_o, soft_restart_o, low_sense_o;
    logic [1:0] link_kind_i, vout_range_o;
    logic [2:0] error_amp_transconductance_o;
    logic [4:0] compensation_resistance_o;
    logic [7:0] link_code_i, shared_rail_address_o, common_status_flags_o;
    logic [15:0] link_wdata_i, sense_temp_coefficient_o, ext_temp_offset_o, wv;
    logic [47:0] link_rdata_o, rd;
    int n_mismatch = 0;
    int checks = 0;
    int n_save = 0, n_erase = 0, n_cmp = 0, n_rst = 0;
    logic [7:0] codes [8] = '{8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hd4, 8'hd3};
    logic [15:0] rstv [8] = '{16'h0010, 16'h0f3c, 16'h03e8, 16'h4000, 16'h8000, 16'h0080, 16'h00c7, 16'h00ae};
    logic [7:0] scode [3] = '{8'hea, 8'hec, 8'hf0};
    logic [11:0] sexp [3] = '{12'h100, 12'h110, 12'h111};
    logic [15:0] temps [3] = '{16'hd810, 16'hd830, 16'hd820};

    always #2 clk_sys_i = ~clk_sys_i;
    // Offset by 1 ns so link edges never meet system edges
    initial
    begin
        #1;
        forever #80 link_clk_i = ~link_clk_i;
    end
    always @(posedge clk_sys_i)
    begin
        n_save <= n_save + int'(nvm_fault_save_o === 1'b1);
        n_erase <= n_erase + int'(nvm_fault_erase_o === 1'b1);
        n_cmp <= n_cmp + int'(nvm_compare_o === 1'b1);
        n_rst <= n_rst + int'(soft_restart_o === 1'b1);
    end

    pmd_decoder #(.CHANNELS(2)) pmd_decoder_i (
        .clk_sys_i, .sys_rst_i, .link_clk_i, .link_rst_i, .link_valid_i, .link_kind_i, .link_code_i,
        .link_wdata_i, .link_extra_i, .link_page_i, .link_done_o, .link_rdata_o, .link_nack_o, .die_temp_i,
        .die_temp_valid_i, .share_clk_tick_i, .nvm_fault_save_o, .nvm_fault_erase_o, .nvm_compare_o,
        .nvm_fault_byte_i, .soft_restart_o, .low_sense_o, .vout_range_o, .error_amp_transconductance_o,
        .compensation_resistance_o, .sense_temp_coefficient_o, .ext_temp_offset_o, .shared_rail_address_o,
        .common_status_flags_o);
    pmd_host_model pmd_host_model_i (
        .link_clk_i, .link_valid_o(link_valid_i), .link_kind_o(link_kind_i), .link_code_o(link_code_i),
        .link_wdata_o(link_wdata_i), .link_extra_o(link_extra_i), .link_page_o(link_page_i),
        .link_done_i(link_done_o), .link_rdata_i(link_rdata_o), .link_nack_i(link_nack_o));

    task automatic summarize();
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xf(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d, input logic e,
                      input logic p);
        pmd_host_model_i.xfer(k, c, d, e, p, rd, nk, ok);
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic rchk(input logic [7:0] c, input logic p, input logic [47:0] exp);
        xf(PMD_K_READ, c, 16'h0000, 1'b0, p);
        check({rd[46:0], nk}, {exp[46:0], 1'b0});
    endtask
    task automatic stat(input logic b);
        xf(PMD_K_READ, 8'hef, 16'h0000, 1'b0, 1'b0);
        check({47'h0, rd[6]}, {47'h0, b});
    endtask

    initial
    begin
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge link_clk_i);
        link_rst_i = 1'b0;
        foreach (codes[i])
            rchk(codes[i], 1'b0, {32'h0, rstv[i]});
        foreach (codes[i])
        begin
            wv = {8'h30 + 8'(i), 8'h5a};
            xf(PMD_K_WRITE, codes[i], wv, 1'b0, 1'b0);
            rchk(codes[i], 1'b0, {32'h0, (i inside {[1:4]}) ? wv : {8'h00, wv[7:0]}});
        end
        check({40'h0, shared_rail_address_o}, 48'h5a);
        check({32'h0, sense_temp_coefficient_o}, 48'h315a);
        check({32'h0, ext_temp_offset_o}, 48'h345a);
        check({40'h0, error_amp_transconductance_o, compensation_resistance_o}, 48'h5a);
        check({46'h0, low_sense_o, vout_range_o[0]}, 48'h1);
        xf(PMD_K_WRITE, 8'hfa, 16'h0011, 1'b0, 1'b1);
        rchk(8'hfa, 1'b1, 48'h11);
        rchk(8'hfa, 1'b0, 48'h5a);
        foreach (scode[i])
        begin
            xf(PMD_K_SEND, scode[i], 16'h0000, 1'b0, 1'b0);
            check({n_save[3:0], n_erase[3:0], n_cmp[3:0], 35'h0, nk}, {sexp[i], 36'h0});
        end
        xf(PMD_K_SEND, 8'hea, 16'h0000, 1'b1, 1'b0);
        check({n_save[3:0], 43'h0, nk}, {4'h1, 44'h1});
        foreach (temps[i])
        begin
            @(negedge clk_sys_i);
            {die_temp_i, die_temp_valid_i} = {temps[i], 1'b1};
            @(negedge clk_sys_i);
            die_temp_valid_i = 1'b0;
        end
        rchk(8'hf4, 1'b0, 48'hd830);
        xf(PMD_K_WRITE, 8'hf4, 16'h1234, 1'b0, 1'b0);
        check({47'h0, nk}, 48'h1);
        rchk(8'hf4, 1'b0, 48'hd830);
        xf(PMD_K_SEND, 8'he3, 16'h0000, 1'b0, 1'b0);
        stat(1'b0);
        xf(PMD_K_WRITE, 8'hb9, 16'h1234, 1'b0, 1'b0);
        stat(1'b1);
        @(negedge clk_sys_i);
        {die_temp_i, die_temp_valid_i} = {16'hd808, 1'b1};
        @(negedge clk_sys_i);
        die_temp_valid_i = 1'b0;
        rchk(8'hf4, 1'b0, 48'hd808);
        rchk(8'h77, 1'b0, 48'h0);
        rchk(8'hee, 1'b0, 48'h3c);
        repeat (10)
        begin
            repeat (4) @(negedge clk_sys_i);
            share_clk_tick_i = ~share_clk_tick_i;
        end
        rchk(8'hfb, 1'b0, 48'h5);
        xf(PMD_K_SEND, 8'hfd, 16'h0000, 1'b0, 1'b0);
        check(48'(n_rst), 48'h1);
        rchk(8'hfa, 1'b0, 48'h80);
        summarize();
    end
endmodule // pmd_decoder_tb_top

// *** pmd_host_model.sv ***
// Host link controller model: one request at a time
`timescale 1ns/1ns
module pmd_host_model (
    // Link clock
    input wire logic link_clk_i,
    // Request
    output logic link_valid_o,
    output logic [1:0] link_kind_o,
    output logic [7:0] link_code_o,
    output logic [15:0] link_wdata_o,
    output logic link_extra_o,
    output logic link_page_o,
    // Answer
    input wire logic link_done_i,
    input wire logic [47:0] link_rdata_i,
    input wire logic link_nack_i
);
    initial
    begin
        {link_valid_o, link_kind_o, link_code_o, link_wdata_o, link_extra_o, link_page_o} = '0;
    end
    // Host keeps to documented codes unless a scenario asks otherwise
    task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d, input logic e,
                        input logic p, output logic [47:0] rd, output logic nk, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(negedge link_clk_i);
        {link_valid_o, link_kind_o, link_code_o, link_wdata_o, link_extra_o, link_page_o} = {1'b1, k, c, d, e, p};
        while (!ok && n < 12)
        begin
            @(negedge link_clk_i);
            n++;
            ok = (link_done_i === 1'b1);
        end
        // Request stands through the edge that samples done; answer taken there
        @(posedge link_clk_i);
        rd = link_rdata_i;
        nk = link_nack_i;
        @(negedge link_clk_i);
        // Flip released fields so a stale request never looks held
        {link_valid_o, link_code_o, link_wdata_o} = {1'b0, ~c, ~d};
    endtask
endmodule // pmd_host_model

// *** pmd_pkg.sv ***
// Package for the manufacturer command decoder: codes, reset values, field positions
package pmd_pkg;
    // Command codes
    localparam logic [7:0] PMD_CMD_FAULT_SAVE = 8'hea;
    localparam logic [7:0] PMD_CMD_FAULT_ERASE = 8'hec;
    localparam logic [7:0] PMD_CMD_FAULT_READ = 8'hee;
    localparam logic [7:0] PMD_CMD_COMMON = 8'hef;
    localparam logic [7:0] PMD_CMD_NVM_COMPARE = 8'hf0;
    localparam logic [7:0] PMD_CMD_DIE_PEAK = 8'hf4;
    localparam logic [7:0] PMD_CMD_PWM_PHASING = 8'hf5;
    localparam logic [7:0] PMD_CMD_SENSE_TC = 8'hf6;
    localparam logic [7:0] PMD_CMD_FILTER_RES = 8'hf7;
    localparam logic [7:0] PMD_CMD_TEMP_SLOPE = 8'hf8;
    localparam logic [7:0] PMD_CMD_TEMP_OFFSET = 8'hf9;
    localparam logic [7:0] PMD_CMD_RAIL_ADDR = 8'hfa;
    localparam logic [7:0] PMD_CMD_CLOCK_COUNT = 8'hfb;
    localparam logic [7:0] PMD_CMD_SOFT_RESTART = 8'hfd;
    localparam logic [7:0] PMD_CMD_PEAK_CLEAR = 8'he3;
    localparam logic [7:0] PMD_CMD_PWM_ENGINE = 8'hd4;
    localparam logic [7:0] PMD_CMD_LOOP_COMP = 8'hd3;
    // Reset values
    localparam logic [7:0] PMD_RST_PWM_PHASING = 8'h10;
    localparam logic [15:0] PMD_RST_SENSE_TC = 16'h0f3c;
    localparam logic [15:0] PMD_RST_FILTER_RES = 16'h03e8;
    localparam logic [15:0] PMD_RST_TEMP_SLOPE = 16'h4000;
    localparam logic [15:0] PMD_RST_TEMP_OFFSET = 16'h8000;
    localparam logic [7:0] PMD_RST_RAIL_ADDR = 8'h80;
    localparam logic [7:0] PMD_RST_PWM_ENGINE = 8'hc7;
    localparam logic [7:0] PMD_RST_LOOP_COMP = 8'hae;
    // Field positions
    localparam int PMD_CML_RO_WRITE_BIT = 6;
    localparam int PMD_ENG_LOW_SENSE_BIT = 2;
    localparam int PMD_ENG_VRANGE_BIT = 1;
    localparam int PMD_L11_EXP_LSB = 11;
    localparam logic [4:0] PMD_L16_EXP = 5'h14;
    localparam int PMD_COUNT_W = 48;
    // Kind of transaction seen on the link
    typedef enum logic [1:0] {PMD_TR_SEND, PMD_TR_WRITE, PMD_TR_READ} pmd_kind_t;
    // Transaction kinds as raw codes for the link side
    localparam logic [1:0] PMD_K_SEND = 2'h0;
    localparam logic [1:0] PMD_K_WRITE = 2'h1;
    localparam logic [1:0] PMD_K_READ = 2'h2;
endpackage
